//--- design/alu_flags_and_data_addressing.sv
// Flag generation and data operand address forming for an 8-bit core
// Assumes the sequencer presents one decoded instruction per valid cycle
// and supplies the file operand read at the previous address
// Operation
// - Flag register as destination of a flag-affecting op takes only the flag update, result dropped
// - Clear aimed at flag register only sets zero flag
// - Flag register bits seven to five always read zero
// - Sign flag bit 4 follows result bit seven, except on clear
// - Overflow flag bit 3 set on signed two's-complement overflow
// - Zero flag bit 2 set when result is zero
// - Add and subtract put carry out of bit three in bit 1
// - Add and subtract put carry out of bit seven in bit 0
// - Subtract adds two's complement; carries read as inverted borrow
// - Rotate through carry loads carry with bit shifted out
// - Branch and call carry a twenty-bit program address
// - File instructions take eight-bit address from low opcode byte
// - Access bit one joins bank value to form twelve-bit address
// - Access bit zero selects access bank, bank value ignored
// - Full twelve-bit opcode addresses ignore bank value
// - Destination bit one writes file, zero writes working register
// - Without destination bit, opcode fixes file or working register
// - Pointer pairs give indirect addresses and are software registers
// - Indirect access reaches pointed location, with step or offset
// - Indexed literal offset mode only when extended bit is set
// - Each pointer pair holds twelve bits, high nibble unused
// - Post step after access, pre-increment before access
// - Pointer steps carry across the pair and leave flags alone
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "alu_flags_regs.svh"
module alu_flags_and_data_addressing
    import alu_flags_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              core_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              instr_valid_in,
    input  wire instr_t            instr_in,
    input  wire logic [7:0]        file_data_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [11:0]       paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic [31:0]            prdata_out,
    output logic [ADDR_W-1:0]      data_addr_out,
    output logic [7:0]             result_out,
    output logic                   file_we_out,
    output logic                   work_we_out,
    output logic [19:0]            prog_addr_out,
    output logic                   prog_load_out,
    output logic [7:0]             flags_out
);

    flags_t            flags_q;
    logic [3:0]        bank_q;
    logic [11:0]       ptr_q [3];
    logic              ext_set_q;
    logic [7:0]        work_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        res_q;
    logic              file_we_q;
    logic              work_we_q;
    logic [19:0]       prog_q;
    logic              prog_ld_q;
    logic              rdy_q;
    logic              err_q;
    logic [31:0]       rdata_q;

    // Operand address forming
    function automatic logic [11:0] form_addr(input instr_t i,
                                              input logic [3:0] bank,
                                              input logic [11:0] ptr,
                                              input logic [7:0] w,
                                              input logic ext);
        logic [11:0] a;
        a = 12'h000;
        case (i.mode)
            AM_FULL: begin
                a = i.full_addr;
            end
            AM_INDIRECT: begin
                case (i.ind)
                    IND_PRE_INC: a = ptr + 12'h001;
                    IND_PLUS_W:  a = ptr + {{4{w[7]}}, w};
                    default:     a = ptr;
                endcase
            end
            AM_DIRECT: begin
                if (i.access_bit) begin
                    a = {bank, i.file_addr};
                end else if (ext && i.file_addr < `ACCESS_SPLIT) begin
                    a = ptr_q_2_sum(i.file_addr);
                end else if (i.file_addr < `ACCESS_SPLIT) begin
                    a = {4'h0, i.file_addr};
                end else begin
                    a = {`ACCESS_HIGH_BANK, i.file_addr};
                end
            end
            default: a = 12'h000;
        endcase
        return a;
    endfunction

    function automatic logic [11:0] ptr_q_2_sum(input logic [7:0] off);
        return ptr_q[2] + {4'h0, off};
    endfunction

    // Flag computation and result
    logic [7:0] res_d;
    flags_t     flags_d;
    logic       affects;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic [7:0] opb;
    logic [11:0] addr_d;
    always_comb begin
        addr_d   = form_addr(instr_in, bank_q, ptr_q[instr_in.ptr_sel],
                             work_q, ext_set_q);
        flags_d  = flags_q;
        affects  = 1'b0;
        res_d    = 8'h00;
        opb      = (instr_in.op == OP_SUB) ? ~instr_in.literal
                                           : instr_in.literal;
        low_sum  = {1'b0, file_data_in[3:0]} + {1'b0, opb[3:0]}
                   + {4'h0, instr_in.op == OP_SUB};
        full_sum = {1'b0, file_data_in} + {1'b0, opb}
                   + {8'h00, instr_in.op == OP_SUB};
        case (instr_in.op)
            OP_ADD, OP_SUB: begin
                res_d      = full_sum[7:0];
                affects    = 1'b1;
                flags_d.dc = low_sum[4];
                flags_d.c  = full_sum[8];
                flags_d.ov = (file_data_in[7] == opb[7])
                             && (res_d[7] != file_data_in[7]);
            end
            OP_AND:  begin res_d = file_data_in & instr_in.literal;
                           affects = 1'b1; end
            OP_OR:   begin res_d = file_data_in | instr_in.literal;
                           affects = 1'b1; end
            OP_XOR:  begin res_d = file_data_in ^ instr_in.literal;
                           affects = 1'b1; end
            OP_COMPLEMENT: begin res_d = ~file_data_in; affects = 1'b1; end
            OP_MOVE: res_d = file_data_in;
            OP_CLEAR: begin res_d = 8'h00; affects = 1'b1; end
            OP_ROT_LEFT_C: begin
                res_d     = {file_data_in[6:0], flags_q.c};
                flags_d.c = file_data_in[7];
                affects   = 1'b1;
            end
            OP_ROT_RIGHT_C: begin
                res_d     = {flags_q.c, file_data_in[7:1]};
                flags_d.c = file_data_in[0];
                affects   = 1'b1;
            end
            default: res_d = 8'h00;
        endcase
        if (affects && instr_in.op != OP_CLEAR) begin
            flags_d.n = res_d[7];
        end
        if (affects) begin
            flags_d.z = (res_d == 8'h00);
        end
    end

    logic to_file;
    always_comb begin
        case (instr_in.dst)
            DST_FILE: to_file = 1'b1;
            DST_WORK: to_file = 1'b0;
            default:  to_file = instr_in.dst_bit;
        endcase
    end

    logic hits_flags;
    assign hits_flags = to_file && (addr_d == `FLAGS_SFR_ADDR)
                        && (instr_in.mode != AM_LITERAL);

    // Datapath outputs
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            addr_q    <= '0;
            res_q     <= 8'h00;
            file_we_q <= 1'b0;
            work_we_q <= 1'b0;
            prog_q    <= 20'h00000;
            prog_ld_q <= 1'b0;
        end else begin
            addr_q    <= ADDR_W'(addr_d);
            res_q     <= res_d;
            file_we_q <= instr_valid_in && to_file && instr_in.op != OP_NONE
                         && !(hits_flags && affects);
            work_we_q <= instr_valid_in && !to_file
                         && instr_in.op != OP_NONE;
            prog_q    <= instr_in.prog_addr;
            prog_ld_q <= instr_valid_in && instr_in.mode == AM_LITERAL
                         && instr_in.op == OP_NONE;
        end
    end

    // Flags, working register and pointers
    logic        apb_wr;
    assign apb_wr = psel_in && penable_in && pwrite_in && pstrb_in[0];

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_q <= `FLAGS_RESET;
        end else if (instr_valid_in && affects) begin
            flags_q <= flags_d;
        end else if (apb_wr && paddr_in == `REG_FLAGS) begin
            flags_q <= pwdata_in[4:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            work_q <= 8'h00;
        end else if (work_we_q) begin
            work_q <= res_q;
        end else if (apb_wr && paddr_in == `REG_WORK) begin
            work_q <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ptr_q[0] <= `PTR_RESET;
            ptr_q[1] <= `PTR_RESET;
            ptr_q[2] <= `PTR_RESET;
        end else if (instr_valid_in && instr_in.mode == AM_INDIRECT) begin
            case (instr_in.ind)
                IND_POST_INC, IND_PRE_INC: ptr_q[instr_in.ptr_sel] <=
                    ptr_q[instr_in.ptr_sel] + 12'h001;
                IND_POST_DEC: ptr_q[instr_in.ptr_sel] <=
                    ptr_q[instr_in.ptr_sel] - 12'h001;
                default: ;
            endcase
        end else if (apb_wr && paddr_in == `REG_PTR0) begin
            ptr_q[0] <= pwdata_in[11:0];
        end else if (apb_wr && paddr_in == `REG_PTR1) begin
            ptr_q[1] <= pwdata_in[11:0];
        end else if (apb_wr && paddr_in == `REG_PTR2) begin
            ptr_q[2] <= pwdata_in[11:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bank_q    <= `BANK_RESET;
            ext_set_q <= 1'b0;
        end else if (apb_wr && paddr_in == `REG_BANK) begin
            bank_q <= pwdata_in[3:0];
        end else if (apb_wr && paddr_in == `REG_CONFIG) begin
            ext_set_q <= pwdata_in[0];
        end
    end

    // APB slave, answers in the first access cycle
    logic [31:0] rd_d;
    logic        err_d;
    always_comb begin
        err_d = 1'b0;
        if (paddr_in == `REG_FLAGS) begin
            rd_d = {27'h0, flags_q};
        end else if (paddr_in == `REG_BANK) begin
            rd_d = {28'h0, bank_q};
        end else if (paddr_in == `REG_PTR0) begin
            rd_d = {20'h0, ptr_q[0]};
        end else if (paddr_in == `REG_PTR1) begin
            rd_d = {20'h0, ptr_q[1]};
        end else if (paddr_in == `REG_PTR2) begin
            rd_d = {20'h0, ptr_q[2]};
        end else if (paddr_in == `REG_CONFIG) begin
            rd_d = {31'h0, ext_set_q};
        end else if (paddr_in == `REG_WORK) begin
            rd_d = {24'h0, work_q};
        end else if (paddr_in == `REG_LAST_ADDR) begin
            rd_d = {20'h0, 12'(addr_q)};
        end else begin
            rd_d  = 32'h0;
            err_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            rdy_q   <= psel_in && !penable_in;
            err_q   <= psel_in && !penable_in && err_d;
            rdata_q <= (psel_in && !penable_in && !pwrite_in) ? rd_d : 32'h0;
        end
    end

    assign pready_out    = rdy_q;
    assign pslverr_out   = err_q;
    assign prdata_out    = rdata_q;
    assign data_addr_out = addr_q;
    assign result_out    = res_q;
    assign file_we_out   = file_we_q;
    assign work_we_out   = work_we_q;
    assign prog_addr_out = prog_q;
    assign prog_load_out = prog_ld_q;
    assign flags_out     = {3'h0, flags_q};

endmodule
`default_nettype wire

//--- design/alu_flags_pkg.sv
// Types shared by the flag and addressing block
// Assumes the constants header sits beside it
`include "alu_flags_regs.svh"
package alu_flags_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOVE,
        OP_CLEAR, OP_ROT_LEFT_C, OP_ROT_RIGHT_C, OP_COMPLEMENT
    } alu_op_t;
    typedef enum logic [2:0] {
        AM_INHERENT, AM_LITERAL, AM_DIRECT, AM_FULL, AM_INDIRECT
    } addr_mode_t;
    typedef enum logic [2:0] {
        IND_PLAIN, IND_POST_INC, IND_POST_DEC, IND_PRE_INC, IND_PLUS_W
    } ind_kind_t;
    typedef enum logic [1:0] {
        DST_BY_BIT, DST_FILE, DST_WORK
    } dst_kind_t;
    typedef struct packed {
        alu_op_t    op;
        addr_mode_t mode;
        ind_kind_t  ind;
        logic [1:0] ptr_sel;
        dst_kind_t  dst;
        logic       dst_bit;
        logic       access_bit;
        logic [7:0] file_addr;
        logic [11:0] full_addr;
        logic [19:0] prog_addr;
        logic [7:0] literal;
    } instr_t;
    typedef struct packed {
        logic       n;
        logic       ov;
        logic       z;
        logic       dc;
        logic       c;
    } flags_t;
endpackage

//--- design/alu_flags_regs.svh
// Offsets, field positions and reset values for the flag and addressing block
// Assumes inclusion by the package, the design module, the checker and the testbench
`ifndef ALU_FLAGS_REGS_SVH
`define ALU_FLAGS_REGS_SVH
`define REG_FLAGS        12'h000
`define REG_BANK         12'h004
`define REG_PTR0         12'h008
`define REG_PTR1         12'h00c
`define REG_PTR2         12'h010
`define REG_CONFIG       12'h014
`define REG_WORK         12'h018
`define REG_LAST_ADDR    12'h01c
`define FLAG_C_BIT       0
`define FLAG_DC_BIT      1
`define FLAG_Z_BIT       2
`define FLAG_OV_BIT      3
`define FLAG_N_BIT       4
`define FLAGS_RESET      5'h00
`define PTR_RESET        12'h000
`define BANK_RESET       4'h0
`define ACCESS_SPLIT     8'h60
`define ACCESS_HIGH_BANK 4'hf
`define FLAGS_SFR_ADDR   12'hfd8
`endif

//--- verif/alu_flags_chk.sv
// Checker for flag and address outputs of the flag block
// Assumes binding onto the block's top module ports
`timescale 1ns/1ns
`default_nettype none
`include "alu_flags_regs.svh"
module alu_flags_chk
    import alu_flags_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              core_clk_in,
    input wire logic              rstn_in,
    input wire logic              instr_valid_in,
    input wire instr_t            instr_in,
    input wire logic [7:0]        file_data_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic              pready_out,
    input wire logic [ADDR_W-1:0] data_addr_out,
    input wire logic              file_we_out,
    input wire logic [19:0]       prog_addr_out,
    input wire logic              prog_load_out,
    input wire logic [7:0]        flags_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    AST_HI_ZERO: assert property (flags_out[7:5] == 3'h0)
        else $error("upper flag bits not zero");
    AST_ADD_DC: assert property (instr_valid_in && instr_in.op == OP_ADD
        |=> flags_out[1] == (({1'b0, $past(file_data_in[3:0])}
        + $past(instr_in.literal[3:0])) > 5'h0f))
        else $error("nibble carry wrong on add");
    AST_ADD_C: assert property (instr_valid_in && instr_in.op == OP_ADD
        |=> flags_out[0] == (({1'b0, $past(file_data_in)}
        + $past(instr_in.literal)) > 9'h0ff))
        else $error("carry wrong on add");
    AST_SUB_C: assert property (instr_valid_in && instr_in.op == OP_SUB
        |=> flags_out[0] == ($past(file_data_in) >= $past(instr_in.literal)))
        else $error("borrow wrong on subtract");
    AST_ROT_L: assert property (instr_valid_in &&
        instr_in.op == OP_ROT_LEFT_C |=> flags_out[0] == $past(file_data_in[7]))
        else $error("carry wrong on left rotate");
    AST_FLAG_DEST: assert property (instr_valid_in && instr_in.op == OP_ADD
        ##1 data_addr_out == `FLAGS_SFR_ADDR |-> !file_we_out)
        else $error("result written over flag register");
    AST_KEEP: assert property (instr_valid_in && instr_in.op == OP_MOVE &&
        !(psel_in && penable_in && pwrite_in)
        |=> $stable(flags_out) || data_addr_out == `FLAGS_SFR_ADDR)
        else $error("flags changed on move");
    AST_LIT: assert property (instr_valid_in &&
        instr_in.mode == AM_LITERAL && instr_in.op == OP_NONE
        |=> prog_load_out && prog_addr_out == $past(instr_in.prog_addr))
        else $error("program address not loaded");
    cover property (instr_valid_in && instr_in.op == OP_SUB);
    cover property (instr_valid_in && instr_in.mode == AM_INDIRECT);
    cover property (psel_in && penable_in && pready_out);
endmodule
bind alu_flags_and_data_addressing alu_flags_chk #(.ADDR_W(ADDR_W)) chk_u (
    .core_clk_in, .rstn_in, .instr_valid_in, .instr_in, .file_data_in,
    .psel_in, .penable_in, .pwrite_in, .pready_out, .data_addr_out,
    .file_we_out, .prog_addr_out, .prog_load_out, .flags_out);
`default_nettype wire

//--- verif/data_mem_model.sv
// Data memory and working register beside the flag block
// Assumes writes arrive as one-cycle strobes with address and data
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
    input wire logic        clk_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0]  data_in,
    input wire logic        we_in,
    input wire logic        work_we_in,
    output logic [7:0]      work_out
);
    logic [7:0] mem [4096];
    always_ff @(posedge clk_in) begin
        if (we_in) mem[addr_in] <= data_in;
        if (work_we_in) work_out <= data_in;
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Testbench for the flag and addressing block
// Assumes the design package, constants header and memory model
`timescale 1ns/1ns
`default_nettype none
`include "alu_flags_regs.svh"
module tb_top;
    import alu_flags_pkg::*;
    logic        core_clk_in, rstn_in, instr_valid_in, ev, s1;
    logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic        file_we_out, work_we_out, prog_load_out;
    logic [11:0] paddr_in, data_addr_out;
    logic [31:0] pwdata_in, prdata_out, rv;
    logic [7:0]  file_data_in, result_out, flags_out, wk, a8, b8;
    logic [19:0] prog_addr_out;
    instr_t      instr_in, it;
    int          err_total, n_tests;
    logic [16:0] tbl [7] = '{ {8'h0f, 8'h01, 1'b0}, {8'hff, 8'h01, 1'b0},
        {8'h7f, 8'h01, 1'b0}, {8'h80, 8'h80, 1'b0}, {8'h05, 8'h03, 1'b1},
        {8'h03, 8'h05, 1'b1}, {8'h80, 8'h01, 1'b1} };
    ind_kind_t   ik [5] = '{IND_POST_INC, IND_PRE_INC, IND_POST_DEC,
        IND_PLAIN, IND_PLUS_W};
    logic [11:0] ia [5] = '{12'h0ff, 12'h101, 12'h101, 12'h100, 12'h0fe};
    logic [11:0] ip [5] = '{12'h100, 12'h101, 12'h100, 12'h100, 12'h100};
    alu_flags_and_data_addressing dut_u (
        .core_clk_in, .rstn_in, .instr_valid_in, .instr_in,
        .file_data_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .pstrb_in(4'hf), .pready_out, .pslverr_out,
        .prdata_out, .data_addr_out, .result_out, .file_we_out,
        .work_we_out, .prog_addr_out, .prog_load_out, .flags_out);
    data_mem_model mem_u (.clk_in(core_clk_in), .addr_in(data_addr_out),
        .data_in(result_out), .we_in(file_we_out),
        .work_we_in(work_we_out), .work_out(wk));
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 64);
        if (k >= 64) err_total++;
        rv = prdata_out;
        ev = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic run(input instr_t i, input logic [7:0] f);
        @(posedge core_clk_in);
        instr_in <= i;
        file_data_in <= f;
        instr_valid_in <= 1'b1;
        @(posedge core_clk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask
    function automatic instr_t mk(input alu_op_t o, input addr_mode_t m,
                                  input logic a, input logic [7:0] f, l);
        instr_t i;
        i = '0;
        i.op = o;
        i.mode = m;
        i.access_bit = a;
        i.file_addr = f;
        i.literal = l;
        return i;
    endfunction
    function automatic logic [31:0] fl(input logic [7:0] a, b, input logic s);
        logic [7:0] bb;
        logic [8:0] r;
        logic [4:0] h;
        bb = s ? ~b : b;
        r = a + bb + 9'(s);
        h = a[3:0] + bb[3:0] + 5'(s);
        return {27'h0, r[7], a[7] == bb[7] && r[7] != a[7], r[7:0] == 8'h00,
                h[4], r[8]};
    endfunction
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        err_total++;
        stop_test();
    end
    initial begin
        {err_total, n_tests} = '0;
        {rstn_in, instr_valid_in, psel_in, penable_in, pwrite_in} = '0;
        {paddr_in, pwdata_in, file_data_in, instr_in} = '0;
        repeat (16) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        apb(1'b0, `REG_FLAGS, 32'h0);
        chk("flags reset", 32'h0, rv);
        apb(1'b1, `REG_FLAGS, 32'hff);
        apb(1'b0, `REG_FLAGS, 32'h0);
        chk("flags read", 32'h1f, rv);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", 32'h1, ev);
        tend("registers");
        for (int j = 0; j < 7; j++) begin
            {a8, b8, s1} = tbl[j];
            run(mk(s1 ? OP_SUB : OP_ADD, AM_DIRECT, 1'b1, 8'h20, b8), a8);
            chk("flags", fl(a8, b8, s1), flags_out);
            chk("result", 8'(s1 ? a8 - b8 : a8 + b8), result_out);
        end
        run(mk(OP_ROT_LEFT_C, AM_DIRECT, 1'b1, 8'h20, 8'h00), 8'h81);
        chk("rotate left", 32'h1, flags_out[0]);
        run(mk(OP_ROT_RIGHT_C, AM_DIRECT, 1'b1, 8'h20, 8'h00), 8'h02);
        chk("rotate right", 32'h0, flags_out[0]);
        tend("arithmetic");
        apb(1'b1, `REG_FLAGS, 32'h13);
        it = mk(OP_CLEAR, AM_DIRECT, 1'b0, 8'hd8, 8'h00);
        it.dst = DST_FILE;
        run(it, 8'h55);
        chk("clear flags", 32'h17, flags_out);
        chk("clear write", 32'h0, file_we_out);
        it = mk(OP_ADD, AM_DIRECT, 1'b0, 8'hd8, 8'h01);
        it.dst_bit = 1'b1;
        run(it, 8'h7f);
        chk("add flags", fl(8'h7f, 8'h01, 1'b0), flags_out);
        chk("add write", 32'h0, file_we_out);
        run(mk(OP_MOVE, AM_DIRECT, 1'b1, 8'h20, 8'h00), 8'h00);
        chk("move flags", 32'h1a, flags_out);
        tend("flag destination");
        apb(1'b1, `REG_BANK, 32'h5);
        it = mk(OP_ADD, AM_DIRECT, 1'b1, 8'h34, 8'h01);
        it.dst_bit = 1'b1;
        run(it, 8'h10);
        chk("bank addr", 32'h534, data_addr_out);
        @(posedge core_clk_in);
        #1;
        chk("file value", 32'h11, mem_u.mem[12'h534]);
        it.dst_bit = 1'b0;
        run(it, 8'h20);
        chk("work strobe", 32'h1, work_we_out);
        @(posedge core_clk_in);
        #1;
        chk("work value", 32'h21, wk);
        it.dst = DST_FILE;
        run(it, 8'hff);
        chk("fixed file", 32'h1, file_we_out);
        tend("destination");
        run(mk(OP_MOVE, AM_DIRECT, 1'b0, 8'h34, 8'h00), 8'h00);
        chk("access low", 32'h034, data_addr_out);
        run(mk(OP_MOVE, AM_DIRECT, 1'b0, 8'h80, 8'h00), 8'h00);
        chk("access high", 32'hf80, data_addr_out);
        it = mk(OP_MOVE, AM_FULL, 1'b1, 8'h34, 8'h00);
        it.full_addr = 12'habc;
        run(it, 8'h00);
        chk("full addr", 32'habc, data_addr_out);
        apb(1'b1, `REG_CONFIG, 32'h1);
        apb(1'b1, `REG_PTR2, 32'h200);
        run(mk(OP_MOVE, AM_DIRECT, 1'b0, 8'h10, 8'h00), 8'h00);
        chk("indexed", 32'h210, data_addr_out);
        apb(1'b1, `REG_CONFIG, 32'h0);
        run(mk(OP_MOVE, AM_DIRECT, 1'b0, 8'h10, 8'h00), 8'h00);
        chk("not indexed", 32'h010, data_addr_out);
        tend("direct");
        apb(1'b1, `REG_PTR0, 32'h0ff);
        apb(1'b1, `REG_WORK, 32'hfe);
        foreach (ik[j]) begin
            it = mk(OP_MOVE, AM_INDIRECT, 1'b1, 8'h00, 8'h00);
            it.ind = ik[j];
            it.dst = DST_FILE;
            run(it, 8'h00);
            chk("ind addr", ia[j], data_addr_out);
            apb(1'b0, `REG_PTR0, 32'h0);
            chk("pointer", ip[j], rv);
        end
        chk("ind flags", 32'h07, flags_out);
        tend("indirect");
        it = mk(OP_NONE, AM_LITERAL, 1'b0, 8'h00, 8'h00);
        it.prog_addr = 20'habcde;
        run(it, 8'h00);
        chk("prog load", 32'h1, prog_load_out);
        chk("prog addr", 32'habcde, prog_addr_out);
        tend("literal");
        stop_test();
    end
endmodule
`default_nettype wire
